//--- rtl/sreg_pkg.sv
`default_nettype none
package sreg_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   // quarter of one serial clock period, made by the host
   localparam int unsigned SCL_QTR_NS = 625;
   localparam int unsigned SCL_QTR_CYC =
      (SCL_QTR_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned REG_DEPTH = 256;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [7:0] BYTEWISE_PORT_OFS = 8'hf0;
   // 7-bit bus identities per strap pair {hi, lo}
   localparam logic [6:0] BUS_ID_00 = 7'h48;
   localparam logic [6:0] BUS_ID_01 = 7'h4c;
   localparam logic [6:0] BUS_ID_10 = 7'h58;
   localparam logic [6:0] BUS_ID_11 = 7'h5c;
   localparam logic DIR_WR = 1'b0;
   localparam logic DIR_RD = 1'b1;
   // host register map, byte addresses
   localparam logic [4:0] CSR_CTRL = 5'h00;
   localparam logic [4:0] CSR_REG = 5'h04;
   localparam logic [4:0] CSR_WDATA = 5'h08;
   localparam logic [4:0] CSR_RDATA = 5'h0c;
   localparam logic [4:0] CSR_STATUS = 5'h10;
   localparam int CTRL_SEL_LSB = 0;
   localparam int CTRL_RD_BIT = 8;
   localparam int CTRL_ONE_BIT = 9;
   localparam int CTRL_GO_BIT = 31;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_NACK_BIT = 1;

   function automatic logic [6:0] bus_id(input logic [1:0] sel);
      case (sel)
         2'h0: bus_id = BUS_ID_00;
         2'h1: bus_id = BUS_ID_01;
         2'h2: bus_id = BUS_ID_10;
         default: bus_id = BUS_ID_11;
      endcase
   endfunction : bus_id
endpackage : sreg_pkg
`default_nettype wire

//--- rtl/sreg_if.sv
`default_nettype none
interface sreg_if;
   logic scl;
   logic sda_host_o;
   logic sda_host_oe;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic sda;
   // open-drain wire with external pull-up
   assign sda = (sda_host_oe ? sda_host_o : 1'b1) &
                (sda_dev_oe ? sda_dev_o : 1'b1);
   modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
   modport host (output scl, output sda_host_o, output sda_host_oe,
                 input sda);
endinterface : sreg_if
`default_nettype wire

//--- rtl/sreg_sync.sv
`default_nettype none
module sreg_sync #(
   parameter int unsigned W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta <= INIT;
         q <= INIT;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : sreg_sync
`default_nettype wire

//--- rtl/sreg_dev_end.sv
// Operation
// - slave only, one of four identities
// - straps pick identity 0x90/0x98/0xb0/0xb8
// - registers are 16 bits, word or byte access
// - start: data falls while clock high
// - stop: data rises while clock high
// - address byte: identity then direction bit
// - transmitter releases data during acknowledge
// - matching address gets acknowledged
// - write: register address byte follows, acknowledged
// - write data two bytes, each acknowledged
// - pointer increments after each written word; a word completed through the byte-wise port leaves it at the port
// - master ends write with start or stop
// - read: address write, restart, read address
// - master nacks last byte, slave releases
// - pointer increments after each read word
// - low byte through byte-wise port register
// - only master makes start and stop
// - data changes only while clock low
// - master clocks, eight bits then acknowledge
// - open-drain data, pull low only
// - register updates only on full word
`default_nettype none
module sreg_dev_end (
   sreg_if.dev link,
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic bus_id_select_lo,
   input wire logic bus_id_select_hi,
   output logic wr_stb,
   output logic [7:0] wr_addr,
   output logic [15:0] wr_data,
   output logic rd_stb,
   output logic [7:0] rd_addr,
   output logic addressed
);
   typedef enum logic [2:0] {
      DS_IDLE,
      DS_ADDR,
      DS_REG,
      DS_WR,
      DS_RD
   } sreg_dev_st_t;

   sreg_dev_st_t state;
   logic scl_s;
   logic sda_s;
   logic [1:0] sel_s;
   logic scl_d;
   logic sda_d;
   logic start_c;
   logic stop_c;
   logic scl_rise;
   logic scl_fall;
   logic [3:0] bit_cnt;
   logic [7:0] shreg;
   logic [7:0] tx;
   logic sda_oe;
   logic rd_dir;
   logic [7:0] ptr;
   logic byte_lo;
   logic [7:0] pend_hi;
   logic [7:0] pend_addr;
   logic [7:0] rd_lo;
   logic [7:0] rd_byte;
   logic [15:0] mem [sreg_pkg::REG_DEPTH];

   // pins come from the far side: two flops each
   sreg_sync #(
      .W(4),
      .INIT(4'hf)
   ) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .d({link.scl, link.sda, bus_id_select_hi, bus_id_select_lo}),
      .q({scl_s, sda_s, sel_s})
   );

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   assign start_c = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_c = scl_s & scl_d & ~sda_d & sda_s;
   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;

   // next byte to send: high half of target, else latched low half
   always_comb begin
      if (byte_lo || ptr == sreg_pkg::BYTEWISE_PORT_OFS) begin
         rd_byte = rd_lo;
      end else begin
         rd_byte = mem[ptr][15:8];
      end
   end

   // protocol engine
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= DS_IDLE;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         tx <= 8'h00;
         sda_oe <= 1'b0;
         rd_dir <= 1'b0;
         ptr <= 8'h00;
         byte_lo <= 1'b0;
         pend_hi <= 8'h00;
         pend_addr <= 8'h00;
         rd_lo <= 8'h00;
         wr_stb <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 16'h0000;
         rd_stb <= 1'b0;
         rd_addr <= 8'h00;
      end else begin
         wr_stb <= 1'b0;
         rd_stb <= 1'b0;
         if (start_c) begin
            state <= DS_ADDR;
            bit_cnt <= 4'h0;
            sda_oe <= 1'b0;
         end else if (stop_c) begin
            state <= DS_IDLE;
            sda_oe <= 1'b0;
         end else if (state != DS_IDLE) begin
            if (scl_rise) begin
               if (bit_cnt < 4'h8) begin
                  shreg <= {shreg[6:0], sda_s};
                  bit_cnt <= bit_cnt + 4'h1;
               end else begin
                  bit_cnt <= 4'h9;
                  if (state == DS_RD && sda_s) begin
                     state <= DS_IDLE;
                  end
               end
            end else if (scl_fall) begin
               if (bit_cnt == 4'h8) begin
                  // acknowledge slot opens
                  case (state)
                     DS_ADDR: begin
                        if (shreg[7:1] == sreg_pkg::bus_id(sel_s)) begin
                           sda_oe <= 1'b1;
                           rd_dir <= shreg[0];
                        end else begin
                           state <= DS_IDLE;
                        end
                     end
                     DS_REG: begin
                        ptr <= shreg;
                        byte_lo <= 1'b0;
                        sda_oe <= 1'b1;
                     end
                     DS_WR: begin
                        sda_oe <= 1'b1;
                        if (byte_lo) begin
                           wr_stb <= 1'b1;
                           wr_addr <= ptr;
                           wr_data <= {pend_hi, shreg};
                           ptr <= ptr + 8'h01;
                           byte_lo <= 1'b0;
                        end else if (ptr == sreg_pkg::BYTEWISE_PORT_OFS) begin
                           wr_stb <= 1'b1;
                           wr_addr <= pend_addr;
                           wr_data <= {pend_hi, shreg};
                        end else begin
                           pend_hi <= shreg;
                           pend_addr <= ptr;
                           byte_lo <= 1'b1;
                        end
                     end
                     default: begin
                        sda_oe <= 1'b0;
                     end
                  endcase
               end else if (bit_cnt == 4'h9) begin
                  // acknowledge slot closes
                  bit_cnt <= 4'h0;
                  sda_oe <= 1'b0;
                  case (state)
                     DS_ADDR: begin
                        state <= rd_dir ? DS_RD : DS_REG;
                     end
                     DS_REG: begin
                        state <= DS_WR;
                     end
                     default: begin
                     end
                  endcase
                  if ((state == DS_ADDR && rd_dir) || state == DS_RD) begin
                     tx <= rd_byte;
                     sda_oe <= ~rd_byte[7];
                     if (byte_lo) begin
                        byte_lo <= 1'b0;
                        ptr <= ptr + 8'h01;
                     end else if (ptr != sreg_pkg::BYTEWISE_PORT_OFS) begin
                        rd_lo <= mem[ptr][7:0];
                        byte_lo <= 1'b1;
                        rd_stb <= 1'b1;
                        rd_addr <= ptr;
                     end
                  end
               end else if (state == DS_RD) begin
                  sda_oe <= ~tx[6];
                  tx <= {tx[6:0], 1'b0};
               end
            end
         end
      end
   end

   // register store, whole words only
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < sreg_pkg::REG_DEPTH; i++) begin
            mem[i] <= sreg_pkg::REG_RESET;
         end
      end else if (wr_stb) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         addressed <= 1'b0;
      end else begin
         addressed <= (state != DS_IDLE) && (state != DS_ADDR);
      end
   end

   // never drives high, never makes start or stop
   assign link.sda_dev_o = 1'b0;
   assign link.sda_dev_oe = sda_oe;
endmodule : sreg_dev_end
`default_nettype wire

//--- rtl/sreg_host_end.sv
`default_nettype none
module sreg_host_end #(
   parameter int unsigned QTR_CYC = sreg_pkg::SCL_QTR_CYC
) (
   sreg_if.host link,
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   typedef enum logic [1:0] {
      M_IDLE,
      M_START,
      M_BIT,
      M_STOP
   } sreg_host_st_t;

   sreg_host_st_t mst;
   logic sda_s;
   logic [1:0] sel;
   logic rd_mode;
   logic one_byte;
   logic [7:0] reg_addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic busy;
   logic nack;
   logic go;
   logic [31:0] csr_rd;
   logic [15:0] qcnt;
   logic tick;
   logic [1:0] phase;
   logic [2:0] step;
   logic [2:0] last_step;
   logic rx_step;
   logic [3:0] bit_idx;
   logic [7:0] txb;
   logic scl;
   logic sda_oe;

   sreg_sync #(
      .W(1),
      .INIT(1'b1)
   ) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .d(link.sda),
      .q(sda_s)
   );

   // byte sent at each step; reads release the line
   function automatic logic [7:0] byte_for(input logic [2:0] s);
      case (s)
         3'h0: byte_for = {sreg_pkg::bus_id(sel), sreg_pkg::DIR_WR};
         3'h1: byte_for = reg_addr;
         3'h2: byte_for = rd_mode ? {sreg_pkg::bus_id(sel), sreg_pkg::DIR_RD}
                                  : wdata[15:8];
         3'h3: byte_for = rd_mode ? 8'hff : wdata[7:0];
         default: byte_for = 8'hff;
      endcase
   endfunction : byte_for

   assign rx_step = rd_mode && (step >= 3'h3);
   assign last_step = rd_mode ? (one_byte ? 3'h3 : 3'h4)
                              : (one_byte ? 3'h2 : 3'h3);
   assign tick = busy && (qcnt == 16'(QTR_CYC - 1));

   always_comb begin
      csr_rd = 32'h0000_0000;
      case (avs_address)
         sreg_pkg::CSR_CTRL: begin
            csr_rd[sreg_pkg::CTRL_SEL_LSB +: 2] = sel;
            csr_rd[sreg_pkg::CTRL_RD_BIT] = rd_mode;
            csr_rd[sreg_pkg::CTRL_ONE_BIT] = one_byte;
         end
         sreg_pkg::CSR_REG: csr_rd[7:0] = reg_addr;
         sreg_pkg::CSR_WDATA: csr_rd[15:0] = wdata;
         sreg_pkg::CSR_RDATA: csr_rd[15:0] = rdata;
         sreg_pkg::CSR_STATUS: begin
            csr_rd[sreg_pkg::STAT_BUSY_BIT] = busy;
            csr_rd[sreg_pkg::STAT_NACK_BIT] = nack;
         end
         default: csr_rd = 32'h0000_0000;
      endcase
   end

   // bus slave: answer one cycle after the request
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
         sel <= 2'h0;
         rd_mode <= 1'b0;
         one_byte <= 1'b0;
         reg_addr <= 8'h00;
         wdata <= 16'h0000;
         go <= 1'b0;
      end else begin
         go <= 1'b0;
         if (avs_waitrequest) begin
            if (avs_read || avs_write) begin
               avs_waitrequest <= 1'b0;
               avs_readdata <= csr_rd;
            end
         end else begin
            avs_waitrequest <= 1'b1;
            if (avs_write && !busy) begin
               case (avs_address)
                  sreg_pkg::CSR_CTRL: begin
                     sel <= avs_writedata[sreg_pkg::CTRL_SEL_LSB +: 2];
                     rd_mode <= avs_writedata[sreg_pkg::CTRL_RD_BIT];
                     one_byte <= avs_writedata[sreg_pkg::CTRL_ONE_BIT];
                     go <= avs_writedata[sreg_pkg::CTRL_GO_BIT];
                  end
                  sreg_pkg::CSR_REG: reg_addr <= avs_writedata[7:0];
                  sreg_pkg::CSR_WDATA: wdata <= avs_writedata[15:0];
                  default: begin
                  end
               endcase
            end
         end
      end
   end

   // quarter-period divider for the serial clock
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         qcnt <= 16'h0000;
      end else if (!busy || go || tick) begin
         qcnt <= 16'h0000;
      end else begin
         qcnt <= qcnt + 16'h0001;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mst <= M_IDLE;
         phase <= 2'h0;
         step <= 3'h0;
         bit_idx <= 4'h0;
         txb <= 8'hff;
         scl <= 1'b1;
         sda_oe <= 1'b0;
         busy <= 1'b0;
         nack <= 1'b0;
         rdata <= 16'h0000;
      end else if (go) begin
         busy <= 1'b1;
         nack <= 1'b0;
         rdata <= 16'h0000;
         step <= 3'h0;
         phase <= 2'h0;
         txb <= byte_for(3'h0);
         mst <= M_START;
      end else if (tick) begin
         phase <= phase + 2'h1;
         case (mst)
            M_START: begin
               case (phase)
                  2'h0: sda_oe <= 1'b0;
                  2'h1: scl <= 1'b1;
                  2'h2: sda_oe <= 1'b1;
                  default: begin
                     scl <= 1'b0;
                     bit_idx <= 4'h0;
                     mst <= M_BIT;
                  end
               endcase
            end
            M_BIT: begin
               case (phase)
                  2'h0: begin
                     if (bit_idx < 4'h8) begin
                        sda_oe <= ~txb[7];
                     end else begin
                        sda_oe <= rx_step && (step != last_step);
                     end
                  end
                  2'h1: scl <= 1'b1;
                  2'h2: begin
                     if (bit_idx < 4'h8) begin
                        if (rx_step) begin
                           rdata <= {rdata[14:0], sda_s};
                        end
                     end else if (!rx_step && sda_s) begin
                        nack <= 1'b1;
                     end
                  end
                  default: begin
                     scl <= 1'b0;
                     if (bit_idx < 4'h8) begin
                        bit_idx <= bit_idx + 4'h1;
                        txb <= {txb[6:0], 1'b1};
                     end else begin
                        bit_idx <= 4'h0;
                        if (nack || step == last_step) begin
                           mst <= M_STOP;
                        end else if (rd_mode && step == 3'h1) begin
                           step <= 3'h2;
                           txb <= byte_for(3'h2);
                           mst <= M_START;
                        end else begin
                           step <= step + 3'h1;
                           txb <= byte_for(step + 3'h1);
                        end
                     end
                  end
               endcase
            end
            M_STOP: begin
               case (phase)
                  2'h0: sda_oe <= 1'b1;
                  2'h1: scl <= 1'b1;
                  2'h2: sda_oe <= 1'b0;
                  default: begin
                     busy <= 1'b0;
                     mst <= M_IDLE;
                  end
               endcase
            end
            default: mst <= M_IDLE;
         endcase
      end
   end

   assign link.scl = scl;
   assign link.sda_host_o = 1'b0;
   assign link.sda_host_oe = sda_oe;
endmodule : sreg_host_end
`default_nettype wire

//--- dv/sreg_properties.sv
`default_nettype none
module sreg_properties #(
   parameter int QTR = 8
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_host_oe,
   input wire logic sda_dev_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] lo_cnt;
   logic [15:0] hi_cnt;
   // cycles the serial clock has spent low and high
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lo_cnt <= 16'h0000;
         hi_cnt <= 16'h0000;
      end else begin
         lo_cnt <= scl ? 16'h0000 : lo_cnt + 16'h0001;
         hi_cnt <= scl ? hi_cnt + 16'h0001 : 16'h0000;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_wire_resolve: assert property (sda ==
      !(sda_host_oe || sda_dev_oe))
      else $error("data line level does not match pull-downs");
   a_dev_drive_late: assert property ($rose(sda_dev_oe) |->
      !scl && !$past(scl) && !$past(scl, 2))
      else $error("device pulled data too soon after clock fall");
   a_dev_release_low: assert property ($fell(sda_dev_oe) |-> !scl)
      else $error("device released data while clock high");
   a_dev_hold_high: assert property (scl && $past(scl) |->
      $stable(sda_dev_oe))
      else $error("device changed data while clock high");
   a_idle_quiet: assert property (hi_cnt > 2 * QTR + 4 |-> !sda_dev_oe)
      else $error("device pulls data on idle bus");
   a_start_by_host: assert property ($fell(sda) && scl && $past(scl) |->
      $rose(sda_host_oe))
      else $error("start condition not made by host");
   a_stop_by_host: assert property ($rose(sda) && scl && $past(scl) |->
      $fell(sda_host_oe) && !sda_dev_oe)
      else $error("stop condition not made by host");
   a_scl_low_len: assert property ($rose(scl) |->
      lo_cnt >= 2 * QTR - 1 && lo_cnt <= 2 * QTR + 1)
      else $error("serial clock low time wrong");
   c_dev_ack: cover property ($rose(sda_dev_oe));
   c_start: cover property ($fell(sda) && scl);
   c_stop: cover property ($rose(sda) && scl);
endmodule : sreg_properties
`default_nettype wire

//--- dv/sensor_register_serial_slave_bench.sv
`default_nettype none
module sensor_register_serial_slave_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int QTR = 8;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic sel_lo = 1'b0;
   logic sel_hi = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic wr_stb;
   logic [7:0] wr_addr;
   logic [15:0] wr_data;
   logic rd_stb;
   logic [7:0] rd_addr;
   logic addressed;
   int failures = 0;
   int total_checks = 0;
   int cycles = 0;
   int n_wr = 0;
   int nbit = 0;
   logic first = 1'b0;
   logic sda_q = 1'b1;
   logic scl_q = 1'b1;
   logic [7:0] sh = 8'h00;
   logic [7:0] addr_byte = 8'h00;
   logic [7:0] last_byte = 8'h00;
   logic [7:0] last_wr_addr = 8'h00;
   logic [15:0] last_wr_data = 16'h0000;
   logic [7:0] last_rd_addr = 8'h00;
   logic addr_q = 1'b0;
   int n_sel = 0;
   sreg_if link();
   sreg_dev_end i_sreg_dev_end (.link(link), .clk_sys(clk_sys),
      .rst_n(rst_n), .bus_id_select_lo(sel_lo), .bus_id_select_hi(sel_hi),
      .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data),
      .rd_stb(rd_stb), .rd_addr(rd_addr), .addressed(addressed));
   sreg_host_end #(.QTR_CYC(QTR)) i_sreg_host_end (.link(link),
      .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   sreg_properties #(.QTR(QTR)) i_sreg_properties (.clk_sys(clk_sys),
      .rst_n(rst_n), .scl(link.scl), .sda(link.sda),
      .sda_host_oe(link.sda_host_oe), .sda_dev_oe(link.sda_dev_oe));
   initial forever #5 clk_sys = ~clk_sys;
   // wire monitor: bytes msb first, first byte after each start
   always @(posedge clk_sys) begin
      scl_q <= link.scl;
      sda_q <= link.sda;
      if (wr_stb === 1'b1) begin
         n_wr <= n_wr + 1;
         last_wr_addr <= wr_addr;
         last_wr_data <= wr_data;
      end
      if (rd_stb === 1'b1) last_rd_addr <= rd_addr;
      // count rises of the selected flag
      addr_q <= addressed;
      if (addressed === 1'b1 && addr_q !== 1'b1) n_sel <= n_sel + 1;
      if (link.scl && scl_q && sda_q && !link.sda) begin
         nbit <= 0;
         first <= 1'b1;
      end else if (link.scl && !scl_q) begin
         if (nbit < 8) begin
            sh <= {sh[6:0], link.sda};
            nbit <= nbit + 1;
         end else begin
            nbit <= 0;
            last_byte <= sh;
            if (first) addr_byte <= sh;
            first <= 1'b0;
         end
      end
   end
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         failures = failures + 1;
         $display("[ERR] %0t timeout", $time);
         tally_and_finish();
      end
   end
   task check(input logic [31:0] got, input logic [31:0] exp,
              input string what);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check
   task av(input logic [4:0] a, input logic rd, input logic [31:0] wd,
           output logic [31:0] q);
      @(posedge clk_sys);
      avs_address <= a;
      avs_read <= rd;
      avs_write <= !rd;
      avs_writedata <= wd;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : av
   task xfer(input logic [1:0] s, input logic rd, input logic one,
             input logic [7:0] r, input logic [15:0] wd,
             output logic [31:0] q, output logic nk);
      logic [31:0] st;
      av(sreg_pkg::CSR_REG, 1'b0, {24'h000000, r}, st);
      av(sreg_pkg::CSR_WDATA, 1'b0, {16'h0000, wd}, st);
      av(sreg_pkg::CSR_CTRL, 1'b0, {1'b1, 21'h0, one, rd, 6'h00, s}, st);
      st = 32'h0000_0001;
      for (int i = 0; i < 4000 && st[0] !== 1'b0; i++)
         av(sreg_pkg::CSR_STATUS, 1'b1, 32'h0, st);
      av(sreg_pkg::CSR_RDATA, 1'b1, 32'h0, q);
      nk = st[1];
   endtask : xfer
   task tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : tally_and_finish
   initial begin
      logic [31:0] q;
      logic nk;
      int base;
      int base_sel;
      logic [7:0] r;
      logic [15:0] w;
      logic [7:0] ids [4];
      ids = '{8'h90, 8'h98, 8'hb0, 8'hb8};
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk_sys);
      for (int s = 0; s < 4; s++) begin
         {sel_hi, sel_lo} <= 2'(s);
         repeat (6) @(posedge clk_sys);
         r = 8'(8'h10 + s);
         w = {8'h02, 8'(8'h84 + s)};
         base = n_wr;
         base_sel = n_sel;
         xfer(2'(s), 1'b0, 1'b0, r, w, q, nk);
         check(addr_byte, ids[s], "write id");
         check(nk, 0, "write ack");
         check(32'(n_wr - base), 1, "commit count");
         check(last_wr_addr, r, "write index");
         check(last_wr_data, w, "write word");
         check(32'(n_sel - base_sel), 1, "selected once");
         check(last_byte, w[7:0], "last wire byte");
         xfer(2'(s ^ 1), 1'b0, 1'b0, r, 16'hffff, q, nk);
         check(nk, 1, "foreign id nack");
         check(32'(n_wr - base), 1, "foreign id ignored");
         check(32'(n_sel - base_sel), 1, "foreign not selected");
         xfer(2'(s), 1'b1, 1'b0, r, 16'h0000, q, nk);
         check(q[15:0], w, "read word");
         check(addr_byte, ids[s] | 8'h01, "read id");
         check(last_rd_addr, r, "read index");
         $display("test identity %0d done", s);
      end
      xfer(2'h3, 1'b1, 1'b0, 8'h33, 16'h0000, q, nk);
      check(q[15:0], sreg_pkg::REG_RESET, "reset value");
      base = n_wr;
      xfer(2'h3, 1'b0, 1'b1, 8'h21, 16'h5a5a, q, nk);
      check(32'(n_wr - base), 0, "half word held");
      xfer(2'h3, 1'b0, 1'b1, 8'hf0, 16'hc3c3, q, nk);
      check(32'(n_wr - base), 1, "byte pair commit");
      check(last_wr_addr, 8'h21, "byte pair index");
      check(last_wr_data, 16'h5ac3, "byte pair word");
      xfer(2'h3, 1'b1, 1'b1, 8'h21, 16'h0000, q, nk);
      check(last_byte, 8'h5a, "upper byte read");
      xfer(2'h3, 1'b1, 1'b1, 8'hf0, 16'h0000, q, nk);
      check(last_byte, 8'hc3, "lower byte read");
      $display("test byte-wise done");
      av(5'h14, 1'b1, 32'h0, q);
      check(q, 32'h0000_0000, "unmapped read");
      $display("test unmapped done");
      tally_and_finish();
   end
endmodule : sensor_register_serial_slave_bench
`default_nettype wire
